// file: rtl/tdc_hit_input_control.sv
// Purpose: Edge selection, stop masking, diagnostic pins and run sequencing.
// Assumes: Pin inputs are asynchronous and pass a three-stage synchroniser.
// Notes:   Times are counted in 4 ns clock cycles; the converter core is outside.
`timescale 1ns/1ns
module tdc_hit_input_control
   import hit_ctrl_pkg::*;
#(
   parameter int DW = 16,               // Width of delay, count and converter result fields.
   parameter int CNV_CAL_CYCLES = 64    // Length of a converter calibration run.
) (
   input  wire logic          mclk_i,            // 250 MHz clock.
   input  wire logic          reset_n_i,         // Synchronous reset, active low.
   input  wire logic [7:0]    addr_i,            // Register byte address.
   input  wire logic [31:0]   wdata_i,           // Write data.
   input  wire logic          wr_i,              // Write strobe.
   input  wire logic          rd_i,              // Read strobe.
   output logic      [31:0]   rdata_o,           // Read data, cycle after strobe.
   input  wire logic          start_pin_i,       // Start pulse input.
   input  wire logic          stop_channel_one_i,// Stop channel one input.
   input  wire logic          stop_channel_two_i,// Stop channel two input.
   input  wire logic          ref_clk_i,         // 32,768 Hz reference pin.
   input  wire logic          comparator_i,      // Internal comparator output.
   input  wire logic          gate_pin_i,        // Start gate pin level in.
   output logic               gate_pin_o,        // Start gate pin drive.
   output logic               gate_pin_oe_o,     // Start gate pin enable.
   input  wire logic          fire_pin_i,        // Fire return pin level in.
   output logic               fire_pin_o,        // Fire return pin drive.
   output logic               fire_pin_oe_o,     // Fire return pin enable.
   output logic               sing_around_o,     // Synchronised sing-around input.
   output logic               start_event_o,     // Accepted start pulse.
   output logic               stop_channel_one_hit_o,       // Accepted stop one hit pulse.
   output logic               stop_channel_two_hit_o        // Accepted stop two hit pulse.
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers: three stages, change counts when stages two and three agree.
   localparam int NIN = 6;
   logic [NIN-1:0] pin_raw;   // Raw pin levels.
   logic [NIN-1:0] pin_lvl;   // Filtered levels.
   logic [NIN-1:0] pin_prev;  // Filtered levels one cycle earlier.
   assign pin_raw = {fire_pin_i, gate_pin_i, ref_clk_i,
                     stop_channel_two_i, stop_channel_one_i, start_pin_i};
   genvar g;
   generate
      for (g = 0; g < NIN; g++) begin : g_sync
         logic [2:0] sh_q;   // Stage one is read only by stage two.
         logic [2:0] sh_d;
         logic       lv_q;   // Accepted level.
         logic       lv_d;
         logic       pv_q;   // Accepted level delayed.
         logic       pv_d;
         always_comb begin
            sh_d = {sh_q[1:0], pin_raw[g]};
            lv_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lv_q;
            pv_d = lv_q;
         end
         always_ff @(posedge mclk_i) begin
            if (!reset_n_i) begin
               sh_q <= 3'h0;
               lv_q <= 1'b0;
               pv_q <= 1'b0;
            end else begin
               sh_q <= sh_d;
               lv_q <= lv_d;
               pv_q <= pv_d;
            end
         end
         assign pin_lvl[g]  = lv_q;
         assign pin_prev[g] = pv_q;
      end
   endgenerate
   logic [NIN-1:0] rise;   // Rising edges of filtered levels.
   logic [NIN-1:0] fall;   // Falling edges of filtered levels.
   assign rise = pin_lvl & ~pin_prev;
   assign fall = ~pin_lvl & pin_prev;

////////////////////////////////////////////////////////////////////////////////
// Configuration registers.
   logic [4:0]    edge_q, edge_d;         // Edge options.
   logic [3:0]    diag_q, diag_d;         // Pin function fields.
   logic [DW-1:0] dly_q [3];              // Stop mask delays, first to third.
   logic [DW-1:0] dly_d [3];
   logic [DW-1:0] calcnt_q, calcnt_d;     // Reference periods for oscillator cal.
   logic          fire_down_q, fire_down_d; // Up/down begins downstream.
   start_gate_pin_function_e  gate_fn;
   fire_return_pin_function_e fire_fn;
   assign gate_fn = start_gate_pin_function_e'(diag_q[DIAG_GATE_LSB +: 2]);
   assign fire_fn = fire_return_pin_function_e'(diag_q[DIAG_FIRE_LSB +: 2]);
   logic cmd_wr;   // Write to command register.
   assign cmd_wr = wr_i && (addr_i == ADDR_CMD);

   // Register writes; unmapped addresses are ignored.
   always_comb begin
      edge_d = edge_q;
      diag_d = diag_q;
      dly_d = dly_q;
      calcnt_d = calcnt_q;
      fire_down_d = fire_down_q;
      if (wr_i) begin
         case (addr_i)
            ADDR_EDGE:   edge_d = wdata_i[4:0];
            ADDR_DIAG:   diag_d = wdata_i[3:0];
            ADDR_DELAY1: dly_d[0] = wdata_i[DW-1:0];
            ADDR_DELAY2: dly_d[1] = wdata_i[DW-1:0];
            ADDR_DELAY3: dly_d[2] = wdata_i[DW-1:0];
            ADDR_CALCNT: calcnt_d = wdata_i[DW-1:0];
            ADDR_CMD:    fire_down_d = wdata_i[CMD_FIRE_DOWN];
            default:     edge_d = edge_q;
         endcase
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         edge_q <= 5'h00;
         diag_q <= 4'h0;          // Zero selects both default input functions.
         dly_q <= '{default: '0};
         calcnt_q <= '0;
         fire_down_q <= 1'b0;
      end else begin
         edge_q <= edge_d;
         diag_q <= diag_d;
         dly_q <= dly_d;
         calcnt_q <= calcnt_d;
         fire_down_q <= fire_down_d;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Edge selection. The gate pin enables start only in its default function.
   logic start_edge, s1_edge, s2_edge, gate_ok;
   assign gate_ok    = (gate_fn != GATE_START_ENABLE) || pin_lvl[4];
   assign start_edge = edge_q[EDGE_START_FALL] ? fall[0] : rise[0];
   assign s1_edge = edge_q[EDGE_S1_BOTH] ? (rise[1] | fall[1]) :
                    (edge_q[EDGE_S1_FALL] ? fall[1] : rise[1]);
   assign s2_edge = edge_q[EDGE_S2_BOTH] ? (rise[2] | fall[2]) :
                    (edge_q[EDGE_S2_FALL] ? fall[2] : rise[2]);

////////////////////////////////////////////////////////////////////////////////
// Sequencer for calibration and flight-time runs.
   seq_state_e    st_q, st_d;
   logic [DW-1:0] cnt_q, cnt_d;        // Reference periods or calibration cycles.
   logic [31:0]   osc_q, osc_d;        // Fast cycles over the reference window.
   logic [DW-1:0] cnv_q, cnv_d;        // Converter calibration result.
   logic          armed_q, armed_d;    // Start accepted, stops being timed.
   logic [DW-1:0] el_q, el_d;          // Cycles since accepted start.
   logic [1:0]    hits_q, hits_d;      // Stop one hits in this run.
   logic [1:0]    s2cnt_q, s2cnt_d;    // Stop two hits in this run.
   logic          pass_q, pass_d;      // Second pass of an up/down run pending.
   logic          up_q, up_d;          // Current run is upstream.
   logic          win;                 // Stop acceptance window.
   logic [DW-1:0] cur_dly;
   assign cur_dly = dly_q[(hits_q > 2'd2) ? 2'd2 : hits_q];
   // Each hit waits for its own delay measured from the start.
   assign win = armed_q && (hits_q < 2'd3) && (el_q >= cur_dly);
   assign start_event_o = (st_q == ST_TOF_RUN) && !armed_q && start_edge && gate_ok;
   assign stop_channel_one_hit_o   = win && s1_edge;
   assign stop_channel_two_hit_o   = armed_q && s2_edge;

   always_comb begin
      st_d = st_q; cnt_d = cnt_q; osc_d = osc_q; cnv_d = cnv_q;
      armed_d = armed_q; el_d = el_q; hits_d = hits_q;
      s2cnt_d = s2cnt_q; pass_d = pass_q; up_d = up_q;
      case (st_q)
         ST_IDLE: begin
            if (cmd_wr && wdata_i[CMD_OSC_CAL]) begin
               st_d = ST_OSC_CAL; cnt_d = '0; osc_d = ZERO32;
            end else if (cmd_wr && wdata_i[CMD_CNV_CAL]) begin
               st_d = ST_CNV_CAL; cnt_d = '0;
            end else if (cmd_wr && (wdata_i[CMD_TOF_SINGLE] || wdata_i[CMD_TOF_UPDOWN])) begin
               st_d = ST_TOF_RUN; armed_d = 1'b0; hits_d = 2'd0; s2cnt_d = 2'd0;
               pass_d = wdata_i[CMD_TOF_UPDOWN] && !wdata_i[CMD_TOF_SINGLE];
               up_d = !(wdata_i[CMD_TOF_UPDOWN] && wdata_i[CMD_FIRE_DOWN]);
            end
         end
         ST_OSC_CAL: begin
            // Counting opens at the first reference rise, so only whole reference
            // periods are measured, whatever the phase of the command write.
            if (cnt_q != '0) osc_d = osc_q + 32'd1;
            if (rise[3]) begin
               cnt_d = cnt_q + 1'b1;
               if (cnt_q >= calcnt_q) st_d = ST_IDLE;
            end
         end
         ST_CNV_CAL: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == DW'(CNV_CAL_CYCLES - 1)) begin
               cnv_d = cnt_q + 1'b1;
               st_d = ST_IDLE;
            end
         end
         ST_TOF_RUN: begin
            if (start_event_o) begin
               armed_d = 1'b1; el_d = '0;
            end else if (armed_q) begin
               el_d = (el_q == '1) ? el_q : el_q + 1'b1;
               if (stop_channel_one_hit_o) hits_d = hits_q + 2'd1;
               if (stop_channel_two_hit_o && s2cnt_q != 2'd3) s2cnt_d = s2cnt_q + 2'd1;
               // A pass ends at the third hit or when time runs out.
               if (hits_d == 2'd3 || el_q == '1) begin
                  armed_d = 1'b0; hits_d = 2'd0; s2cnt_d = 2'd0;
                  if (pass_q) begin
                     pass_d = 1'b0; up_d = !up_q;
                  end else begin
                     st_d = ST_IDLE;
                  end
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         st_q <= ST_IDLE; cnt_q <= '0; osc_q <= ZERO32; cnv_q <= '0;
         armed_q <= 1'b0; el_q <= '0; hits_q <= 2'd0; s2cnt_q <= 2'd0;
         pass_q <= 1'b0; up_q <= 1'b0;
      end else begin
         st_q <= st_d; cnt_q <= cnt_d; osc_q <= osc_d; cnv_q <= cnv_d;
         armed_q <= armed_d; el_q <= el_d; hits_q <= hits_d; s2cnt_q <= s2cnt_d;
         pass_q <= pass_d; up_q <= up_d;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Diagnostic pins, registered so the pins never glitch.
   logic [1:0] div_q, div_d;    // Reference edges within a half period.
   logic       ck4_q, ck4_d;    // Reference divided by eight.
   logic       gpo_q, gpo_d, gpe_q, gpe_d, fpo_q, fpo_d, fpe_q, fpe_d, sa_q, sa_d;
   always_comb begin
      div_d = div_q; ck4_d = ck4_q;
      if (rise[3]) begin
         div_d = (div_q == 2'(REF_DIV_HALF - 1)) ? 2'd0 : div_q + 2'd1;
         if (div_q == 2'(REF_DIV_HALF - 1)) ck4_d = !ck4_q;
      end
      gpe_d = (gate_fn == GATE_DIRECTION) || (gate_fn == GATE_REF_DIV8);
      case (gate_fn)
         GATE_DIRECTION: gpo_d = (st_q == ST_TOF_RUN) && up_q;
         GATE_REF_DIV8:  gpo_d = ck4_q;
         default:        gpo_d = 1'b0;
      endcase
      fpe_d = (fire_fn != FIRE_SING_AROUND);
      case (fire_fn)
         FIRE_STOP_WINDOW: fpo_d = win;
         FIRE_COMPARATOR:  fpo_d = comparator_i;
         FIRE_REF_CLOCK:   fpo_d = pin_lvl[3];
         default:          fpo_d = 1'b0;
      endcase
      sa_d = (fire_fn == FIRE_SING_AROUND) && pin_lvl[5];
   end
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         div_q <= 2'd0; ck4_q <= 1'b0; gpo_q <= 1'b0; gpe_q <= 1'b0;
         fpo_q <= 1'b0; fpe_q <= 1'b0; sa_q <= 1'b0;
      end else begin
         div_q <= div_d; ck4_q <= ck4_d; gpo_q <= gpo_d; gpe_q <= gpe_d;
         fpo_q <= fpo_d; fpe_q <= fpe_d; sa_q <= sa_d;
      end
   end
   assign gate_pin_o = gpo_q;
   assign gate_pin_oe_o = gpe_q;
   assign fire_pin_o = fpo_q;
   assign fire_pin_oe_o = fpe_q;
   assign sing_around_o = sa_q;

////////////////////////////////////////////////////////////////////////////////
// Read port: data stand in the cycle after the strobe only.
   logic [31:0] rd_q, rd_d;
   always_comb begin
      rd_d = ZERO32;
      if (rd_i) begin
         case (addr_i)
            ADDR_EDGE:   rd_d = {27'h0, edge_q};
            ADDR_DIAG:   rd_d = {28'h0, diag_q};
            ADDR_DELAY1: rd_d = 32'(dly_q[0]);
            ADDR_DELAY2: rd_d = 32'(dly_q[1]);
            ADDR_DELAY3: rd_d = 32'(dly_q[2]);
            ADDR_CALCNT: rd_d = 32'(calcnt_q);
            ADDR_STATUS: rd_d = {23'h0, s2cnt_q, hits_q, up_q, armed_q, st_q};
            ADDR_OSCRES: rd_d = osc_q;
            ADDR_CNVRES: rd_d = 32'(cnv_q);
            default:     rd_d = ZERO32;
         endcase
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) rd_q <= ZERO32;
      else rd_q <= rd_d;
   end
   assign rdata_o = rd_q;

////////////////////////////////////////////////////////////////////////////////
// Checks.
   property p_gate_default;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (gate_fn == GATE_START_ENABLE) && $stable(gate_fn) |=> !gate_pin_oe_o;
   endproperty
   a_gate_default: assert property (p_gate_default) else $error("gate pin driven");
   property p_dir;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (gate_fn == GATE_DIRECTION) |=> gate_pin_o == ($past(st_q) == ST_TOF_RUN && $past(up_q));
   endproperty
   a_dir: assert property (p_dir) else $error("direction pin wrong");
   property p_win;
      @(posedge mclk_i) disable iff (!reset_n_i)
      stop_channel_one_hit_o |-> armed_q && el_q >= cur_dly;
   endproperty
   a_win: assert property (p_win) else $error("stop hit inside mask");
   property p_fire_win;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (fire_fn == FIRE_STOP_WINDOW) |=> fire_pin_o == $past(win);
   endproperty
   a_fire_win: assert property (p_fire_win) else $error("window pin wrong");
   property p_cmp;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (fire_fn == FIRE_COMPARATOR) |=> fire_pin_o == $past(comparator_i);
   endproperty
   a_cmp: assert property (p_cmp) else $error("comparator pin wrong");
   property p_sa;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (fire_fn == FIRE_SING_AROUND) && $stable(fire_fn) |=> !fire_pin_oe_o;
   endproperty
   a_sa: assert property (p_sa) else $error("fire pin driven");
   property p_cnv;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (st_q == ST_IDLE) && cmd_wr && wdata_i[CMD_CNV_CAL] && !wdata_i[CMD_OSC_CAL]
      |=> (st_q == ST_CNV_CAL) [*8];
   endproperty
   a_cnv: assert property (p_cnv) else $error("calibration run cut short");
   property p_fall;
      @(posedge mclk_i) disable iff (!reset_n_i)
      start_event_o |-> (edge_q[EDGE_START_FALL] ? fall[0] : rise[0]) && gate_ok;
   endproperty
   a_fall: assert property (p_fall) else $error("start on wrong edge");
   property p_ref_out;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (fire_fn == FIRE_REF_CLOCK) |=> fire_pin_o == $past(pin_lvl[3]);
   endproperty
   a_ref_out: assert property (p_ref_out) else $error("reference pin wrong");
   // A stop edge that arrives while its mask is still closed.
   c_mask:   cover property (@(posedge mclk_i) armed_q && !win && s1_edge);
   c_updown: cover property (@(posedge mclk_i) pass_q ##1 !pass_q && st_q == ST_TOF_RUN);
   c_three:  cover property (@(posedge mclk_i) stop_channel_one_hit_o && hits_q == 2'd2);
   c_osc:    cover property (@(posedge mclk_i) st_q == ST_OSC_CAL ##1 st_q == ST_IDLE);
endmodule

// file: include/hit_ctrl_pkg.sv
// Purpose: Shared constants for the hit input control block.
// Assumes: One 250 MHz clock; reference clock arrives as a pin input.
// Notes:   Register offsets are byte addresses on the plain register port.
//
// Summary of operation
// - Start edge falling when option set, else rising.
// - Stop one edge falling when option set.
// - Stop one both-edges option counts every transition.
// - Stop two edge falling when option set.
// - Stop two both-edges option counts every transition.
// - Default start gate pin is high-active start enable.
// - Direction function drives high during upstream run.
// - Clock function drives reference divided by eight.
// - Default fire return pin is sing-around input.
// - Window function drives the stop acceptance window.
// - Comparator function routes comparator to pin.
// - Reference function drives reference clock out.
// - Oscillator calibration counts over reference periods.
// - Converter calibration runs and result is readable.
// - Single command runs exactly one sequence.
// - Up/down command runs two sequences, both directions.
// - First three stop one hits each masked separately.
// - Up/down starts downstream when downstream fire chosen.
package hit_ctrl_pkg;
   localparam logic [7:0] ADDR_EDGE   = 8'h00;  // Edge options.
   localparam logic [7:0] ADDR_DIAG   = 8'h04;  // Pin function selects.
   localparam logic [7:0] ADDR_DELAY1 = 8'h08;  // First hit mask delay.
   localparam logic [7:0] ADDR_DELAY2 = 8'h0C;  // Second hit mask delay.
   localparam logic [7:0] ADDR_DELAY3 = 8'h10;  // Third hit mask delay.
   localparam logic [7:0] ADDR_CALCNT = 8'h14;  // Reference periods for calibration.
   localparam logic [7:0] ADDR_CMD    = 8'h18;  // Command strobes, write only.
   localparam logic [7:0] ADDR_STATUS = 8'h1C;  // Busy, direction, hit counts.
   localparam logic [7:0] ADDR_OSCRES = 8'h20;  // Oscillator calibration result.
   localparam logic [7:0] ADDR_CNVRES = 8'h24;  // Converter calibration result.
   localparam int EDGE_START_FALL = 0;  // Edge register bit positions.
   localparam int EDGE_S1_FALL    = 1;
   localparam int EDGE_S1_BOTH    = 2;
   localparam int EDGE_S2_FALL    = 3;
   localparam int EDGE_S2_BOTH    = 4;
   localparam int DIAG_GATE_LSB   = 0;  // Start gate function field.
   localparam int DIAG_FIRE_LSB   = 2;  // Fire return function field.
   localparam int CMD_OSC_CAL     = 0;  // Command bit positions.
   localparam int CMD_CNV_CAL     = 1;
   localparam int CMD_TOF_SINGLE  = 2;
   localparam int CMD_TOF_UPDOWN  = 3;
   localparam int CMD_FIRE_DOWN   = 4;  // Direction choice for up/down.
   localparam int REF_DIV_HALF    = 4;  // Reference edges per half period of /8 clock.
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   typedef enum logic [1:0] {
      GATE_START_ENABLE = 2'b00,
      GATE_DIRECTION    = 2'b01,
      GATE_REF_DIV8     = 2'b10
   } start_gate_pin_function_e;
   typedef enum logic [1:0] {
      FIRE_SING_AROUND  = 2'b00,
      FIRE_STOP_WINDOW  = 2'b01,
      FIRE_COMPARATOR   = 2'b10,
      FIRE_REF_CLOCK    = 2'b11
   } fire_return_pin_function_e;
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_OSC_CAL = 3'b001,
      ST_CNV_CAL = 3'b010,
      ST_TOF_RUN = 3'b011
   } seq_state_e;
endpackage

// file: verification/pulse_source_model.sv
// Purpose: Pulse sources and reference clock beside the hit input block.
// Assumes: Pins change just after a bench clock edge.
// Notes:   The reference runs fast so that divider checks stay short.
`timescale 1ns/1ns
module pulse_source_model #(
   parameter int REF_HALF = 80          // Reference half period in ns.
) (
   input  wire logic       mclk_i,      // Bench clock for pin timing.
   output logic      [3:0] pins_o,      // Start, stop one, stop two, gate.
   output logic            ref_clk_o    // Free-running reference clock.
);
   ////////////////////////////////////////////////////////////////////////
   // All pins idle low, so the start gate stays shut until opened.
   initial begin
      pins_o = 4'h0;
      ref_clk_o = 1'b0;
      forever #(REF_HALF) ref_clk_o = ~ref_clk_o;
   end
   ////////////////////////////////////////////////////////////////////////
   // One pin per call; bit 3 high opens the start gate.
   task automatic drive(input int idx, input logic val);
      @(posedge mclk_i);
      pins_o[idx] <= val;
   endtask
endmodule

// file: verification/testbench.sv
// Purpose: Self-checking bench for the hit input control block.
// Assumes: Partner model drives the pins and the reference clock.
// Notes:   Pin changes need four cycles to reach the hit pulses.
`timescale 1ns/1ns
module testbench;
   import hit_ctrl_pkg::*;
   logic        mclk_i, reset_n_i, wr_i, rd_i, cmp, fire_drv; // Clock, reset, drives.
   logic [7:0]  addr_i;                                        // Register address.
   logic [31:0] wdata_i, rdata, v;                             // Bus data, last read.
   logic [3:0]  pins;                                          // Partner pin levels.
   logic        ref_clk, gate_o, gate_oe, fire_o, fire_oe;     // Pin drives.
   logic        sing, se, h1, h2;                              // Block pulses.
   int          n_fail, n_compared, cs, c1, c2, gt, ft;        // Counters.
   pulse_source_model pulse_source_model_i (.mclk_i(mclk_i), .pins_o(pins),
      .ref_clk_o(ref_clk));
   tdc_hit_input_control tdc_hit_input_control_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
      .start_pin_i(pins[0]), .stop_channel_one_i(pins[1]), .stop_channel_two_i(pins[2]),
      .ref_clk_i(ref_clk), .comparator_i(cmp), .gate_pin_i(gate_oe ? gate_o : pins[3]),
      .gate_pin_o(gate_o), .gate_pin_oe_o(gate_oe), .fire_pin_i(fire_oe ? fire_o : fire_drv),
      .fire_pin_o(fire_o), .fire_pin_oe_o(fire_oe), .sing_around_o(sing),
      .start_event_o(se), .stop_channel_one_hit_o(h1), .stop_channel_two_hit_o(h2));
   ////////////////////////////////////////////////////////////////////////
   // Clock at 4 ns; pulses counted per cycle, pin drives per toggle.
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cs <= cs + int'(se === 1'b1);
      c1 <= c1 + int'(h1 === 1'b1);
      c2 <= c2 + int'(h2 === 1'b1);
   end
   always @(gate_o) gt = gt + 1;
   always @(fire_o) ft = ft + 1;
   ////////////////////////////////////////////////////////////////////////
   // Bus, pin and checking tasks.
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(negedge mclk_i);
      v = rdata;
   endtask
   // Cleared on the falling edge, away from the counting edge.
   task automatic clr;
      @(negedge mclk_i);
      {cs, c1, c2, gt, ft} = '0;
   endtask
   task automatic pin(input int i, input logic b);
      pulse_source_model_i.drive(i, b);
      repeat (8) @(posedge mclk_i);
   endtask
   // One start pulse and three stop one pulses make a full pass.
   task automatic tof;
      pin(0, 1'b1);
      pin(0, 1'b0);
      repeat (3) begin
         pin(1, 1'b1);
         pin(1, 1'b0);
      end
   endtask
   task automatic idle;
      for (int k = 0; k < 200; k++) begin
         rd(ADDR_STATUS);
         if (v[2:0] === ST_IDLE) break;
      end
   endtask
   task automatic stop_test;
      if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // A hang costs a mismatch; the tests need well under 10000 cycles.
   initial begin
      repeat (20000) @(posedge mclk_i);
      n_fail++;
      stop_test();
   end
   initial begin
      {reset_n_i, wr_i, rd_i, cmp, fire_drv, addr_i, wdata_i} = '0;
      repeat (6) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      wr(ADDR_CMD, 32'h0000_0004);
      pin(0, 1'b1);
      chk("start_gated", cs, 0);
      pin(0, 1'b0);
      pin(3, 1'b1);
      pin(0, 1'b1);
      chk("start_rise", cs, 1);
      pin(2, 1'b1);
      pin(2, 1'b0);
      chk("stop_channel_two_rise", c2, 1);
      repeat (4) tof();
      chk("stop_channel_one_rise", c1, 3);
      // Falling start edge and both-edge options on both stop channels.
      clr();
      wr(ADDR_EDGE, 32'h0000_001F);
      wr(ADDR_CMD, 32'h0000_0004);
      pin(0, 1'b1);
      chk("start_rise_skip", cs, 0);
      pin(0, 1'b0);
      chk("start_fall", cs, 1);
      pin(2, 1'b1);
      pin(2, 1'b0);
      chk("stop_channel_two_both", c2, 2);
      pin(1, 1'b1);
      pin(1, 1'b0);
      chk("stop_channel_one_both", c1, 2);
      pin(1, 1'b1);
      pin(1, 1'b0);
      chk("stop_channel_one_third", c1, 3);
      // Second hit masked while the first passes freely.
      clr();
      wr(ADDR_EDGE, 32'h0000_0000);
      wr(ADDR_DELAY2, 32'h0000_00C8);
      wr(ADDR_DIAG, 32'h0000_0004);
      wr(ADDR_CMD, 32'h0000_0004);
      pin(0, 1'b1);
      pin(0, 1'b0);
      repeat (2) pin(1, 1'b1);
      pin(1, 1'b0);
      pin(1, 1'b1);
      pin(1, 1'b0);
      chk("mask_second", c1, 1);
      chk("win_shut", {fire_oe, fire_o}, 2'b10);
      repeat (200) @(posedge mclk_i);
      chk("win_open", {fire_oe, fire_o}, 2'b11);
      tof();
      chk("mask_open", c1, 3);
      wr(ADDR_DELAY2, 32'h0000_0000);
      // Up/down runs: downstream first when fire down is set.
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_DIAG, 32'h0000_0001);
         wr(ADDR_CMD, k ? 32'h0000_0008 : 32'h0000_0018);
         repeat (4) @(posedge mclk_i);
         chk("dir_first", {gate_oe, gate_o}, {1'b1, k[0]});
         tof();
         chk("dir_second", gate_o, !k[0]);
         tof();
         idle();
         chk("dir_idle", {v[2:0], gate_o}, 4'h0);
      end
      // Reference outputs: window of sixteen reference periods.
      wr(ADDR_DIAG, 32'h0000_000E);
      @(gate_o);
      @(gate_o);
      repeat (6) @(posedge mclk_i);
      clr();
      repeat (640) @(posedge mclk_i);
      chk("ref_div8", gt, 4);
      chk("ref_out", ft, 32);
      wr(ADDR_DIAG, 32'h0000_0008);
      cmp <= 1'b1;
      repeat (8) @(posedge mclk_i);
      chk("cmp_hi", {fire_oe, fire_o}, 2'b11);
      cmp <= 1'b0;
      repeat (8) @(posedge mclk_i);
      chk("cmp_lo", {fire_oe, fire_o}, 2'b10);
      wr(ADDR_DIAG, 32'h0000_0000);
      fire_drv <= 1'b1;
      repeat (8) @(posedge mclk_i);
      chk("sing", {fire_oe, gate_oe, sing}, 3'b001);
      // Calibration runs; two reference periods are 80 cycles.
      wr(ADDR_CALCNT, 32'h0000_0002);
      wr(ADDR_CMD, 32'h0000_0001);
      idle();
      rd(ADDR_OSCRES);
      chk("osc_cal", v > 75 && v < 85, 1);
      wr(ADDR_CMD, 32'h0000_0002);
      rd(ADDR_STATUS);
      chk("cnv_run", v[2:0], ST_CNV_CAL);
      idle();
      chk("cnv_done", v[2:0], ST_IDLE);
      rd(ADDR_CNVRES);
      chk("cnv_res", v, 64);
      stop_test();
   end
endmodule
